// ==== bench/bsdr_host_model.sv ====
// Host model: issues single register reads and writes on the access port.
// Assumes one clock and the one-cycle answer of the register bank.
`timescale 1ns/1ns
module bsdr_host_model (
    // Clock
    input wire logic core_clk,
    // Access port towards the bank
    output logic [6:0] reg_addr,
    output logic reg_rd_strobe,
    output logic reg_wr_strobe,
    output logic [15:0] reg_wr_data,
    input wire logic [15:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    // Idle state at time zero
    initial begin
        reg_addr = 7'h00;
        reg_rd_strobe = 1'h0;
        reg_wr_strobe = 1'h0;
        reg_wr_data = 16'h0000;
    end
    // One request held across a single edge; the answer is taken one cycle on
    task automatic xfer(input logic [6:0] a, input logic wr, input logic [15:0] wd,
                        output logic [15:0] d, output logic v);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd_strobe = ~wr;
        reg_wr_strobe = wr;
        reg_wr_data = wd;
        @(posedge core_clk);
        #1;
        d = reg_rd_data;
        v = reg_rd_valid;
        reg_rd_strobe = 1'h0;
        reg_wr_strobe = 1'h0;
        // Scramble released lines so a stale address cannot pass by luck
        reg_addr = ~a;
        reg_wr_data = ~wd;
    endtask
endmodule

// ==== bench/bsdr_regs_bench.sv ====
// Self-checking bench for the diagnostic register bank.
// Assumes the bank answers a read one cycle after its strobe.
`timescale 1ns/1ns
module bsdr_regs_bench;
    // Design pins driven or watched here
    logic core_clk, rst, soft_reset_pulse, restart_pulse, reg_rd_strobe, reg_wr_strobe;
    logic [6:0] reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data, seen;
    logic reg_rd_valid, vld;
    logic [5:0] ov_event;
    logic [2:0] meas_valid;
    logic [2:0][5:0] m_on, m_off, m_rise, m_fall;
    // Expected words: status, delay 1-3, edge 1-3, unmapped
    logic [15:0] exp_word [8];
    int error_cnt, checked;
    bsdr_regs u_bsdr_regs (.core_clk(core_clk), .rst(rst), .soft_reset_pulse(soft_reset_pulse),
        .restart_pulse(restart_pulse), .reg_addr(reg_addr), .reg_rd_strobe(reg_rd_strobe),
        .reg_wr_strobe(reg_wr_strobe), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .ov_event(ov_event), .meas_valid(meas_valid),
        .meas_turnon_count(m_on), .meas_turnoff_count(m_off), .meas_rise_count(m_rise),
        .meas_fall_count(m_fall));
    bsdr_host_model u_bsdr_host_model (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_rd_strobe(reg_rd_strobe), .reg_wr_strobe(reg_wr_strobe),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));
    // 100 MHz clock
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Inputs always change 1 ns after the rising edge
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    // Read one register by index; a status read empties the expected flags
    task automatic rd_chk(input int i);
        logic [6:0] a;
        a = bsdr_pkg::BSDR_ADDR_OV_STATUS + 7'(i);
        u_bsdr_host_model.xfer(a, 1'h0, 16'h0000, seen, vld);
        chk("read valid", {15'h0000, vld}, 16'h0001);
        chk($sformatf("register %h", a), seen, exp_word[i]);
        if (i == 0) begin
            exp_word[0] = 16'h0000;
        end
    endtask
    task automatic chk_all();
        for (int i = 0; i < 8; i++) rd_chk(i);
    endtask
    // One-cycle detector pulse
    task automatic pulse_ov(input logic [5:0] m);
        step();
        ov_event = m;
        step();
        ov_event = 6'h00;
    endtask
    // Hang guard, well beyond the roughly 140 cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        $display("watchdog expired");
        give_verdict();
    end
    initial begin
        {rst, soft_reset_pulse, restart_pulse, ov_event, meas_valid} = '1;
        {m_on, m_off, m_rise, m_fall} = '0;
        {soft_reset_pulse, restart_pulse, ov_event, meas_valid} = '0;
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'h0;
        foreach (exp_word[i]) exp_word[i] = 16'h0000;
        chk_all();
        $display("test power-on values done");
        // Each detector alone, then the flag must be gone after one read
        for (int i = 0; i < 6; i++) begin
            pulse_ov(6'(1 << i));
            exp_word[0] = 16'(1 << i);
            rd_chk(0);
            rd_chk(0);
        end
        $display("test flags done");
        // New event in the very cycle of the clearing read must survive
        pulse_ov(6'h01);
        exp_word[0] = 16'h0001;
        fork
            rd_chk(0);
            pulse_ov(6'h01);
        join
        exp_word[0] = 16'h0001;
        rd_chk(0);
        rd_chk(0);
        $display("test event during read done");
        // Load bridges one at a time, with boundary counts
        for (int b = 0; b < 3; b++) begin
            m_on[b] = 6'h3f - 6'(b);
            m_off[b] = 6'h20 + 6'(b);
            m_rise[b] = 6'h01 + 6'(b);
            m_fall[b] = 6'h3e - 6'(b);
            exp_word[1 + b] = {2'h0, m_off[b], 2'h0, m_on[b]};
            exp_word[4 + b] = {2'h0, m_fall[b], 2'h0, m_rise[b]};
            meas_valid = 3'(1 << b);
            step();
            meas_valid = 3'h0;
        end
        {m_on, m_off, m_rise, m_fall} = '1;
        chk_all();
        $display("test counts done");
        // Writes everywhere must change nothing and get no answer
        pulse_ov(6'h2a);
        exp_word[0] = 16'h002a;
        for (int i = 0; i < 8; i++) begin
            u_bsdr_host_model.xfer(bsdr_pkg::BSDR_ADDR_OV_STATUS + 7'(i), 1'h1, 16'hffff,
                seen, vld);
            chk("write answer", {15'h0000, vld}, 16'h0000);
            chk("write data", seen, 16'h0000);
        end
        // Restart keeps flags and counts
        step();
        restart_pulse = 1'h1;
        step();
        restart_pulse = 1'h0;
        chk_all();
        $display("test writes and restart done");
        // Soft reset clears flags and counts alike
        pulse_ov(6'h15);
        soft_reset_pulse = 1'h1;
        step();
        soft_reset_pulse = 1'h0;
        foreach (exp_word[i]) exp_word[i] = 16'h0000;
        chk_all();
        $display("test soft reset done");
        give_verdict();
    end
endmodule

// ==== hw/bsdr_pkg.sv ====
// Constants for the bridge switching diagnostic register bank.
// Assumes a register access port driven by the device's serial frame decoder.
// Contract
// - High-side 1/2/3 flags bits 0/2/4, clear-on-read
// - Low-side 1/2 flags bits 1/3, clear-on-read
// - Low-side 3 flag bit 5, same behaviour
// - Restart zeroes status bits 15,11,7,6, keeps rest
// - Power-on or soft reset zeroes every register
// - Restart zeroes timing reserved bits, keeps fields
// - Turn-off delay count in bits 13:8
// - Turn-on delay count in bits 5:0
// - Bridges 1,2 fall count in bits 13:8
// - Bridges 1,2 rise count in bits 5:0
// - Bridge 3 edge register, same layout
// - Timing reserved bits 15:14, 7:6 read zero
package bsdr_pkg;
    // Register access port geometry
    localparam int BSDR_ADDR_W = 7;
    localparam int BSDR_DATA_W = 16;
    localparam int BSDR_CNT_W = 6;
    localparam int BSDR_BRIDGES = 3;
    localparam int BSDR_FLAGS = 6;
    // Register addresses
    localparam logic [6:0] BSDR_ADDR_OV_STATUS = 7'h52;
    localparam logic [6:0] BSDR_ADDR_DELAY1 = 7'h53;
    localparam logic [6:0] BSDR_ADDR_DELAY2 = 7'h54;
    localparam logic [6:0] BSDR_ADDR_DELAY3 = 7'h55;
    localparam logic [6:0] BSDR_ADDR_EDGE1 = 7'h56;
    localparam logic [6:0] BSDR_ADDR_EDGE2 = 7'h57;
    localparam logic [6:0] BSDR_ADDR_EDGE3 = 7'h58;
    // Field positions inside a timing word
    localparam int BSDR_HI_LSB = 8;
    localparam int BSDR_LO_LSB = 0;
    // Status flag positions: high side i at 2i, low side i at 2i+1
    localparam int BSDR_HS_BIT0 = 0;
    localparam int BSDR_LS_BIT0 = 1;
    // Reset values
    localparam logic [15:0] BSDR_RESET_WORD = 16'h0000;
    localparam logic [5:0] BSDR_FLAGS_RESET = 6'h00;
    localparam logic [5:0] BSDR_CNT_RESET = 6'h00;
    // Weight of one timing count, in ns
    localparam real BSDR_COUNT_LSB_NS = 53.3;
    // Decoded register selector
    typedef enum logic [2:0] {
        BSDR_SEL_NONE = 3'h0,
        BSDR_SEL_STATUS = 3'h1,
        BSDR_SEL_DELAY = 3'h2,
        BSDR_SEL_EDGE = 3'h3
    } bsdr_sel_t;
endpackage

// ==== hw/bsdr_regs.sv ====
// Diagnostic register bank: overvoltage flags and switching time counts.
// Assumes detector pulses, measurement strobes, restart and soft reset all
// come from logic on core_clk, and the serial decoder gives one-cycle strobes.
`timescale 1ns/1ns
module bsdr_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Device reset events
    input wire logic soft_reset_pulse,
    input wire logic restart_pulse,
    // Register access from the serial frame decoder
    input wire logic [6:0] reg_addr,
    input wire logic reg_rd_strobe,
    input wire logic reg_wr_strobe,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    // Overvoltage detector pulses, bit 2i high side, 2i+1 low side
    input wire logic [5:0] ov_event,
    // Measured switching times per bridge
    input wire logic [2:0] meas_valid,
    input wire logic [2:0][5:0] meas_turnon_count,
    input wire logic [2:0][5:0] meas_turnoff_count,
    input wire logic [2:0][5:0] meas_rise_count,
    input wire logic [2:0][5:0] meas_fall_count
);

    // Register selection for an address
    function automatic bsdr_pkg::bsdr_sel_t addr_sel(input logic [6:0] a);
        unique case (a)
            bsdr_pkg::BSDR_ADDR_OV_STATUS: addr_sel = bsdr_pkg::BSDR_SEL_STATUS;
            bsdr_pkg::BSDR_ADDR_DELAY1,
            bsdr_pkg::BSDR_ADDR_DELAY2,
            bsdr_pkg::BSDR_ADDR_DELAY3: addr_sel = bsdr_pkg::BSDR_SEL_DELAY;
            bsdr_pkg::BSDR_ADDR_EDGE1,
            bsdr_pkg::BSDR_ADDR_EDGE2,
            bsdr_pkg::BSDR_ADDR_EDGE3: addr_sel = bsdr_pkg::BSDR_SEL_EDGE;
            default: addr_sel = bsdr_pkg::BSDR_SEL_NONE;
        endcase
    endfunction

    // Bridge index for a timing address
    function automatic logic [1:0] addr_bridge(input logic [6:0] a);
        unique case (a)
            bsdr_pkg::BSDR_ADDR_DELAY2, bsdr_pkg::BSDR_ADDR_EDGE2: addr_bridge = 2'h1;
            bsdr_pkg::BSDR_ADDR_DELAY3, bsdr_pkg::BSDR_ADDR_EDGE3: addr_bridge = 2'h2;
            default: addr_bridge = 2'h0;
        endcase
    endfunction

    // Pack two counts into a timing word, reserved bits zero
    function automatic logic [15:0] pack_word(input logic [5:0] hi, input logic [5:0] lo);
        pack_word = {2'h0, hi, 2'h0, lo};
    endfunction

    // Sticky overvoltage flags
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    // Timing fields per bridge
    logic [2:0][5:0] turnon_reg;
    logic [2:0][5:0] turnon_next;
    logic [2:0][5:0] turnoff_reg;
    logic [2:0][5:0] turnoff_next;
    logic [2:0][5:0] rise_reg;
    logic [2:0][5:0] rise_next;
    logic [2:0][5:0] fall_reg;
    logic [2:0][5:0] fall_next;
    // Registered read answer
    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    // Decoded access
    bsdr_pkg::bsdr_sel_t rd_sel;
    logic [1:0] rd_bridge;
    logic status_read;

    assign rd_sel = addr_sel(reg_addr);
    assign rd_bridge = addr_bridge(reg_addr);
    assign status_read = reg_rd_strobe && (rd_sel == bsdr_pkg::BSDR_SEL_STATUS);

    // Flag next state: set beats the read clear so no event is lost.
    // Writes never reach the flags; restart keeps them since only the
    // unimplemented and reserved bits are cleared then.
    always_comb begin
        if (soft_reset_pulse) begin
            flags_next = bsdr_pkg::BSDR_FLAGS_RESET;
        end else if (status_read) begin
            flags_next = ov_event;
        end else begin
            flags_next = flags_reg | ov_event;
        end
    end

    // Timing next state: clear on soft reset, else load on a measurement strobe, otherwise hold.
    // Restart and host writes leave the fields untouched.
    always_comb begin
        turnon_next = turnon_reg;
        turnoff_next = turnoff_reg;
        rise_next = rise_reg;
        fall_next = fall_reg;
        for (int b = 0; b < bsdr_pkg::BSDR_BRIDGES; b++) begin
            if (soft_reset_pulse) begin
                turnon_next[b] = bsdr_pkg::BSDR_CNT_RESET;
                turnoff_next[b] = bsdr_pkg::BSDR_CNT_RESET;
                rise_next[b] = bsdr_pkg::BSDR_CNT_RESET;
                fall_next[b] = bsdr_pkg::BSDR_CNT_RESET;
            end else if (meas_valid[b]) begin
                turnon_next[b] = meas_turnon_count[b];
                turnoff_next[b] = meas_turnoff_count[b];
                rise_next[b] = meas_rise_count[b];
                fall_next[b] = meas_fall_count[b];
            end
        end
    end

    // Read answer: shows the value held before this cycle's updates.
    // Unmapped reads answer zero; writes get no answer at all.
    always_comb begin
        rd_valid_next = reg_rd_strobe;
        rd_data_next = bsdr_pkg::BSDR_RESET_WORD;
        if (reg_rd_strobe) begin
            unique case (rd_sel)
                bsdr_pkg::BSDR_SEL_STATUS: begin
                    // Upper bits and bits 7:6 read zero
                    rd_data_next = {10'h000, flags_reg};
                end
                bsdr_pkg::BSDR_SEL_DELAY: begin
                    rd_data_next = pack_word(turnoff_reg[rd_bridge], turnon_reg[rd_bridge]);
                end
                bsdr_pkg::BSDR_SEL_EDGE: begin
                    rd_data_next = pack_word(fall_reg[rd_bridge], rise_reg[rd_bridge]);
                end
                bsdr_pkg::BSDR_SEL_NONE: begin
                    rd_data_next = bsdr_pkg::BSDR_RESET_WORD;
                end
            endcase
        end
    end

    // State registers; power-on reset loads zero everywhere
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_reg <= bsdr_pkg::BSDR_FLAGS_RESET;
            turnon_reg <= '0;
            turnoff_reg <= '0;
            rise_reg <= '0;
            fall_reg <= '0;
            rd_data_reg <= bsdr_pkg::BSDR_RESET_WORD;
            rd_valid_reg <= 1'h0;
        end else begin
            flags_reg <= flags_next;
            turnon_reg <= turnon_next;
            turnoff_reg <= turnoff_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;

    // Checks on the bank's behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // A status read in a cycle with no soft reset pulse
    sequence read_status_s;
        status_read && !soft_reset_pulse;
    endsequence

    // A quiet cycle: nothing but a possible write or restart
    sequence quiet_s;
        !soft_reset_pulse && !reg_rd_strobe && (ov_event == 6'h00) && (meas_valid == 3'h0);
    endsequence

    property flag_sets_p;
        !soft_reset_pulse && (ov_event != 6'h00)
            |=> ((flags_reg & $past(ov_event)) == $past(ov_event));
    endproperty

    AST_FLAG_SET: assert property (flag_sets_p)
        else $error("Overvoltage event did not set its flag");
    AST_READ_CLEARS: assert property (read_status_s ##0 (ov_event == 6'h00) |=>
        (flags_reg == 6'h00))
        else $error("Status read did not clear the flags");
    AST_SET_WINS: assert property (read_status_s |=> (flags_reg == $past(ov_event)))
        else $error("Event during read clear was lost");
    AST_READ_DATA: assert property (read_status_s |=>
        reg_rd_valid && (reg_rd_data == {10'h000, $past(flags_reg)}))
        else $error("Status read answered the wrong word");
    AST_RESERVED_ZERO: assert property (reg_rd_valid |->
        (reg_rd_data[15:14] == 2'h0) && (reg_rd_data[7:6] == 2'h0))
        else $error("Reserved bits read nonzero");
    AST_WRITE_NO_EFFECT: assert property (reg_wr_strobe ##0 quiet_s |=>
        $stable(flags_reg) && $stable(turnon_reg) && $stable(fall_reg))
        else $error("Host write changed register contents");
    AST_SOFT_RESET: assert property (soft_reset_pulse |=> (flags_reg == 6'h00) &&
        (turnon_reg == '0) && (turnoff_reg == '0) && (rise_reg == '0) && (fall_reg == '0))
        else $error("Soft reset left a register nonzero");
    AST_RESTART_KEEPS: assert property (restart_pulse ##0 quiet_s |=>
        $stable(flags_reg) && $stable(turnoff_reg) && $stable(rise_reg))
        else $error("Restart altered kept contents");
    AST_MEAS_LOAD: assert property (meas_valid[2] && !soft_reset_pulse |=>
        (turnoff_reg[2] == $past(meas_turnoff_count[2])) &&
        (fall_reg[2] == $past(meas_fall_count[2])))
        else $error("Bridge 3 measurement not captured");
    AST_DELAY_LAYOUT: assert property (reg_rd_strobe &&
        (reg_addr == bsdr_pkg::BSDR_ADDR_DELAY1)
        |=> (reg_rd_data[13:8] == $past(turnoff_reg[0])) &&
        (reg_rd_data[5:0] == $past(turnon_reg[0])))
        else $error("Delay word fields misplaced");
    AST_EDGE_LAYOUT: assert property (reg_rd_strobe &&
        (reg_addr == bsdr_pkg::BSDR_ADDR_EDGE2)
        |=> (reg_rd_data[13:8] == $past(fall_reg[1])) &&
        (reg_rd_data[5:0] == $past(rise_reg[1])))
        else $error("Edge word fields misplaced");
    AST_RESTART_TIMING: assert property (restart_pulse ##0 quiet_s |=>
        $stable(turnon_reg) && $stable(fall_reg))
        else $error("Restart altered timing fields");
    // A write carrying data must draw no answer; the output stays at zero
    AST_WRITE_NO_ANSWER: assert property (reg_wr_strobe && (reg_wr_data != 16'h0000)
        ##0 quiet_s |=> !reg_rd_valid && (reg_rd_data == bsdr_pkg::BSDR_RESET_WORD))
        else $error("Host write drew a read answer");

endmodule
